/* fhc_host.v */
// Purpose: host controller driving a 32K x 8 ferroelectric memory port
// Assumes: 10 MHz clk; power-down request from system logic on clk
// Notes: one access at a time; strobes and pins all come from flip-flops
`timescale 1ns/1ns
`include "fram_host_map.vh"
module fhc_host #(
	parameter ADDR_W    = 15,
	parameter DATA_W    = 8,
	parameter PWRUP_CYC = `FHC_PWRUP_CYC
) (
	input  wire              clk,
	input  wire              rst_n,
	input  wire              reqValid,
	output wire              reqReady,
	input  wire              reqWrite,
	input  wire [ADDR_W-1:0] reqAddr,
	input  wire [DATA_W-1:0] reqWdata,
	output reg               rspValid,
	output reg  [DATA_W-1:0] rspRdata,
	input  wire              pwrDownReq,
	output reg               pwrDownSafe,
	output reg               selN,
	output reg               wrStrobeN,
	output reg               outStrobeN,
	output reg  [ADDR_W-1:0] addr_lines,
	output reg  [DATA_W-1:0] dataOut,
	output reg               dataOe,
	input  wire [DATA_W-1:0] dataIn
);
	// ****************************************************************
	// states
	// ****************************************************************
	localparam [2:0] ST_PWRUP = 3'h0;
	localparam [2:0] ST_IDLE  = 3'h1;
	localparam [2:0] ST_READ  = 3'h2;
	localparam [2:0] ST_WRITE = 3'h3;
	localparam [2:0] ST_HIGH  = 3'h4;
	localparam [2:0] ST_DOWN  = 3'h5;
	localparam [2:0] ST_OFF   = 3'h6;
	// ****************************************************************
	// timing counts
	// ****************************************************************
	// raw counts as 32-bit integers
	localparam [31:0] PWRUP_RAW = PWRUP_CYC;
	localparam [31:0] ACC_RAW   = `FHC_ACCESS_CYC;
	localparam [31:0] SETUP_RAW = `FHC_SETUP_CYC;
	localparam [31:0] HIGH_RAW  = `FHC_HIGH_CYC;
	localparam [31:0] REL_RAW   = `FHC_RELEASE_CYC;
	localparam [31:0] CYC_RAW   = `FHC_CYCLE_CYC;
	localparam [31:0] DOWN_RAW  = `FHC_PWRDN_CYC;
	// cut to the counter width on purpose
	localparam [15:0] PWRUP_CNT = PWRUP_RAW[15:0];
	localparam [15:0] ACC_CNT   = ACC_RAW[15:0];
	localparam [15:0] SETUP_CNT = SETUP_RAW[15:0];
	localparam [15:0] HIGH_CNT  = HIGH_RAW[15:0];
	localparam [15:0] REL_CNT   = REL_RAW[15:0];
	localparam [15:0] CYC_CNT   = CYC_RAW[15:0];
	localparam [15:0] DOWN_CNT  = DOWN_RAW[15:0];
	// ****************************************************************
	// reset release and input synchronising
	// ****************************************************************
	reg  [1:0]        rstSync_ff;
	wire              rstN;
	wire [DATA_W-1:0] dataInSync;
	reg  [2:0]        state_ff;
	reg  [2:0]        nxt_state;
	reg  [15:0]       cnt_ff;
	reg  [15:0]       nxt_cnt;
	reg  [15:0]       cyc_ff;
	reg  [15:0]       nxt_cyc;
	// two-stage reset release
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rstSync_ff <= 2'h0;
		end else begin
			rstSync_ff <= {rstSync_ff[0], 1'b1};
		end
	end
	assign rstN = rstSync_ff[1];
	// data lines pass two flip-flops
	fhc_sync #(
		.WIDTH (DATA_W)
	) uSync (
		.clk  (clk),
		.rstN (rstN),
		.din  (dataIn),
		.dout (dataInSync)
	);
	// ****************************************************************
	// sequencing
	// ****************************************************************
	// ready only in idle with the cycle spacing met
	assign reqReady = (state_ff == ST_IDLE) && (cyc_ff >= CYC_CNT)
		&& !pwrDownReq;
	// next-state logic
	always @* begin
		nxt_state = state_ff;
		nxt_cnt   = cnt_ff + 16'h0001;
		nxt_cyc   = (cyc_ff < CYC_CNT) ? cyc_ff + 16'h0001 : cyc_ff;
		case (state_ff)
			ST_PWRUP: begin
				// select stays high while power settles
				if (cnt_ff >= PWRUP_CNT - 16'h0001) begin
					nxt_state = ST_IDLE;
					nxt_cnt   = 16'h0000;
				end
			end
			ST_IDLE: begin
				// power-down wins over a new access
				if (pwrDownReq) begin
					nxt_state = ST_DOWN;
					nxt_cnt   = 16'h0000;
				end else if (reqValid && reqReady) begin
					nxt_state = reqWrite ? ST_WRITE : ST_READ;
					nxt_cnt   = 16'h0000;
					nxt_cyc   = 16'h0001;
				end
			end
			ST_READ: begin
				// sample after both delays plus two sync stages
				if (cnt_ff >= ACC_CNT + 16'h0002) begin
					nxt_state = ST_HIGH;
					nxt_cnt   = 16'h0000;
				end
			end
			ST_WRITE: begin
				// strobe width and data setup
				if (cnt_ff >= ((ACC_CNT > SETUP_CNT) ? ACC_CNT : SETUP_CNT)
					- 16'h0001) begin
					nxt_state = ST_HIGH;
					nxt_cnt   = 16'h0000;
				end
			end
			ST_HIGH: begin
				// select high width and data release
				if (cnt_ff >= ((HIGH_CNT > REL_CNT) ? HIGH_CNT : REL_CNT)
					- 16'h0001) begin
					nxt_state = ST_IDLE;
					nxt_cnt   = 16'h0000;
				end
			end
			ST_DOWN: begin
				// select high long enough before power goes
				if (cnt_ff >= DOWN_CNT - 16'h0001) begin
					nxt_state = ST_OFF;
				end
			end
			ST_OFF: begin
				// wait for the system to restore power
				nxt_cnt = cnt_ff;
				if (!pwrDownReq) begin
					nxt_state = ST_IDLE;
				end
			end
			default: begin
				nxt_state = ST_PWRUP;
				nxt_cnt   = 16'h0000;
			end
		endcase
	end
	// state registers
	always @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			state_ff <= ST_PWRUP;
			cnt_ff   <= 16'h0000;
			cyc_ff   <= 16'h0000;
		end else begin
			state_ff <= nxt_state;
			cnt_ff   <= nxt_cnt;
			cyc_ff   <= nxt_cyc;
		end
	end
	// ****************************************************************
	// pin drive
	// ****************************************************************
	// strobes, address and data from flip-flops
	always @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			selN       <= 1'b1;
			wrStrobeN  <= 1'b1;
			outStrobeN <= 1'b1;
			addr_lines <= {ADDR_W{1'b0}};
			dataOut    <= {DATA_W{1'b0}};
			dataOe     <= 1'b0;
		end else begin
			// select low only in an access
			selN <= !((nxt_state == ST_READ) || (nxt_state == ST_WRITE));
			// one strobe at a time
			outStrobeN <= !(nxt_state == ST_READ);
			wrStrobeN  <= !(nxt_state == ST_WRITE);
			dataOe     <= (nxt_state == ST_WRITE);
			if (state_ff == ST_IDLE && nxt_state != ST_IDLE
				&& nxt_state != ST_DOWN) begin
				// address held for the whole access
				addr_lines <= reqAddr;
				dataOut    <= reqWdata;
			end
		end
	end
	// ****************************************************************
	// responses to the requester
	// ****************************************************************
	// done pulse, read byte and power-down status
	always @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			rspValid    <= 1'b0;
			rspRdata    <= {DATA_W{1'b0}};
			pwrDownSafe <= 1'b0;
		end else begin
			rspValid    <= 1'b0;
			pwrDownSafe <= (nxt_state == ST_OFF);
			// read byte taken as the read ends
			if (state_ff == ST_READ && nxt_state == ST_HIGH) begin
				rspRdata <= dataInSync;
				rspValid <= 1'b1;
			end
			// write done once the strobe rises
			if (state_ff == ST_WRITE && nxt_state == ST_HIGH) begin
				rspValid <= 1'b1;
			end
		end
	end
endmodule // fhc_host

/* fram_host_map.vh */
// Purpose: timing constants for the ferroelectric memory host controller
// Assumes: 10 MHz clock, period 100 ns
// Notes: figures kept in their own unit, cycle counts derived from them
`ifndef FRAM_HOST_MAP_VH
`define FRAM_HOST_MAP_VH
// ****************************************************************
// timing figures
// ****************************************************************
`define FHC_CLK_PERIOD_NS      100
`define FHC_ACCESS_NS          70
`define FHC_CYCLE_NS           150
`define FHC_HIGH_NS            80
`define FHC_RELEASE_NS         25
`define FHC_PWRUP_US           50
`define FHC_PWRDN_NS           100
`define FHC_DATA_SETUP_NS      40
// least times round up to whole cycles
`define FHC_CYC_UP(ns) (((ns) + `FHC_CLK_PERIOD_NS - 1) / `FHC_CLK_PERIOD_NS)
`define FHC_ACCESS_CYC    `FHC_CYC_UP(`FHC_ACCESS_NS)
`define FHC_CYCLE_CYC     `FHC_CYC_UP(`FHC_CYCLE_NS)
`define FHC_HIGH_CYC      `FHC_CYC_UP(`FHC_HIGH_NS)
`define FHC_RELEASE_CYC   `FHC_CYC_UP(`FHC_RELEASE_NS)
`define FHC_PWRDN_CYC     `FHC_CYC_UP(`FHC_PWRDN_NS)
`define FHC_SETUP_CYC     `FHC_CYC_UP(`FHC_DATA_SETUP_NS)
`define FHC_PWRUP_CYC     `FHC_CYC_UP(`FHC_PWRUP_US * 1000)
`endif

/* fhc_sync.v */
// Purpose: two flip-flop synchroniser, one per bit
// Assumes: async reset to zero
// Notes: first stage read only by second stage
`timescale 1ns/1ns
module fhc_sync #(
	parameter WIDTH = 8
) (
	input  wire             clk,
	input  wire             rstN,
	input  wire [WIDTH-1:0] din,
	output wire [WIDTH-1:0] dout
);
	reg [WIDTH-1:0] meta_ff;
	reg [WIDTH-1:0] sync_ff;
	// ****************************************************************
	// two stages per bit
	// ****************************************************************
	genvar gi;
	generate
		for (gi = 0; gi < WIDTH; gi = gi + 1) begin : gBit
			// capture then settle
			always @(posedge clk or negedge rstN) begin
				if (!rstN) begin
					meta_ff[gi] <= 1'b0;
					sync_ff[gi] <= 1'b0;
				end else begin
					meta_ff[gi] <= din[gi];
					sync_ff[gi] <= meta_ff[gi];
				end
			end
		end
	endgenerate
	assign dout = sync_ff;
endmodule // fhc_sync

/* fhc_checker.sv */
// Purpose: port checks for fhc_host
// Assumes: 100 ns clock, reset low active
// Notes: bound to fhc_host in the bench file
`timescale 1ns/1ns
module fhc_checker #(
	parameter PWRUP_CYC = 500,
	parameter ADDR_W    = 15
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic reqValid,
	input wire logic reqReady,
	input wire logic rspValid,
	input wire logic pwrDownSafe,
	input wire logic selN,
	input wire logic wrStrobeN,
	input wire logic outStrobeN,
	input wire logic dataOe,
	input wire logic [ADDR_W-1:0] addr_lines
);
	// least select fall spacing, 150 ns in 100 ns cycles
	localparam int GAP_MIN = 2;
	logic [15:0] upCnt_ff;
	logic [15:0] fallGap_ff;
	logic        selPrev_ff;
	// cycles since select last fell, saturating
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			selPrev_ff <= 1'b1;
			fallGap_ff <= 16'hFFFF;
		end else begin
			selPrev_ff <= selN;
			if (selPrev_ff && !selN)
				fallGap_ff <= 16'h0001;
			else if (fallGap_ff != 16'hFFFF)
				fallGap_ff <= fallGap_ff + 16'h0001;
		end
	end
	// cycles since reset release
	always_ff @(posedge clk or negedge rst_n)
		if (!rst_n) upCnt_ff <= 16'h0000;
		else if (upCnt_ff != 16'hFFFF) upCnt_ff <= upCnt_ff + 16'h0001;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	// read: strobe low, then pulse with pins released
	sequence rdHold; !outStrobeN[*2]; endsequence
	sequence rdEnd; outStrobeN && selN && rspValid; endsequence
	// write: strobe low with data driven, then pulse with pins released
	sequence wrOn; !selN && dataOe; endsequence
	sequence wrEnd; wrStrobeN && selN && rspValid; endsequence
	chk_no_overlap: assert property (wrStrobeN || outStrobeN)
		else $error("both strobes low");
	chk_read_wait: assert property ($fell(outStrobeN) |->
		rdHold ##[1:4] rdEnd) else $error("read timing wrong");
	chk_write_end: assert property ($fell(wrStrobeN) |->
		wrOn ##1 wrEnd) else $error("write timing wrong");
	chk_fall_space: assert property ($fell(selN) |->
		fallGap_ff >= GAP_MIN) else $error("select falls too close");
	chk_addr_hold: assert property (!selN && !$past(selN) |->
		$stable(addr_lines)) else $error("address moved in access");
	chk_pwrup_idle: assert property (upCnt_ff < PWRUP_CYC + 2 |->
		selN && !reqReady) else $error("early access");
	chk_pwrdn_idle: assert property (pwrDownSafe |->
		selN && $past(selN) && !reqReady) else $error("unsafe power-down");
	chk_take_sel: assert property (reqValid && reqReady |=> !selN)
		else $error("select not asserted");
	chk_mode_sel: assert property (!wrStrobeN || !outStrobeN |-> !selN)
		else $error("strobe outside select");
	chk_drive_wr: assert property (dataOe |-> outStrobeN)
		else $error("data driven in read");
endmodule // fhc_checker

/* fhc_mem_model.sv */
// Purpose: behavioural model of the memory pins
// Assumes: pin delays in ns
// Notes: released data lines show the inverse of their last value
`timescale 1ns/1ns
module fhc_mem_model (
	input  wire logic        selN,
	input  wire logic        wrStrobeN,
	input  wire logic        outStrobeN,
	input  wire logic [14:0] addr_lines,
	input  wire logic [7:0]  dataOut,
	input  wire logic        dataOe,
	output wire logic [7:0]  dq
);
	logic [7:0]  mem [0:32767];
	logic [14:0] latAddr;
	logic [7:0]  lastDq = 8'h00;
	logic        rdOn = 1'b0;
	logic        wrPend = 1'b0;
	// address taken just after select falls, clear of the pin update
	always @(negedge selN) #1 latAddr = addr_lines;
	always @(negedge wrStrobeN) wrPend = 1'b1;
	// capture at whichever strobe rises first
	always @(posedge wrStrobeN or posedge selN)
		if (wrPend) begin
			mem[latAddr] = dq;
			wrPend = 1'b0;
		end
	// drive after both access delays, release within 25 ns
	always @(selN or outStrobeN or wrStrobeN)
		if (!selN && !outStrobeN && wrStrobeN) rdOn <= #70 1'b1;
		else rdOn <= #25 1'b0;
	always @(dq) if (dataOe || rdOn) lastDq = dq;
	assign #1 dq = dataOe ? dataOut : (rdOn ? mem[latAddr] : ~lastDq);
endmodule // fhc_mem_model

/* fhc_host_tb.sv */
// Purpose: self-checking bench for fhc_host
// Assumes: 100 ns clock, inputs driven on the falling edge
// Notes: power-up wait shortened to 4 cycles
`timescale 1ns/1ns
module fhc_host_tb;
	localparam PUP = 4;
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        reqValid = 1'b0;
	logic        reqWrite = 1'b0;
	logic [14:0] reqAddr = 15'h0000;
	logic [7:0]  reqWdata = 8'h00;
	logic        pwrDownReq = 1'b0;
	logic        reqReady, rspValid, pwrDownSafe, selN, wrStrobeN;
	logic        outStrobeN, dataOe;
	logic [7:0]  rspRdata, dataOut, dq;
	logic [14:0] addr_lines;
	int          num_errors = 0;
	int          check_count = 0;
	int          cycles = 0;
	logic [14:0] adr [3] = '{15'h0000, 15'h7FFF, 15'h1234};
	logic [7:0]  dat [3] = '{8'h5A, 8'hA5, 8'h3C};
	initial forever #50 clk = ~clk;
	fhc_host #(.PWRUP_CYC(PUP)) dut_u (.clk, .rst_n, .reqValid, .reqReady,
		.reqWrite, .reqAddr, .reqWdata, .rspValid, .rspRdata, .pwrDownReq,
		.pwrDownSafe, .selN, .wrStrobeN, .outStrobeN, .addr_lines,
		.dataOut, .dataOe, .dataIn(dq));
	fhc_mem_model mem_u (.selN, .wrStrobeN, .outStrobeN, .addr_lines,
		.dataOut, .dataOe, .dq);
	task automatic chk(string nm, logic [14:0] e, logic [14:0] g);
		check_count++;
		if (g !== e) begin
			num_errors++;
			$display("[FAIL] %s exp %h got %h", nm, e, g);
		end
	endtask
	// bounded wait on a flag, checked at falling edges
	task automatic waitHi(string nm, ref logic s, input int lim,
		output int n);
		n = 0;
		while (s !== 1'b1 && n < lim) begin
			@(negedge clk);
			n++;
		end
		chk(nm, 15'h1, {14'h0, s});
	endtask
	// one access: hold request until taken, then wait the pulse
	task automatic acc(logic w, logic [14:0] a, logic [7:0] d,
		output logic [7:0] r);
		int n;
		reqValid = 1'b1;
		reqWrite = w;
		reqAddr = a;
		reqWdata = d;
		waitHi("taken", reqReady, 50, n);
		@(negedge clk);
		reqValid = 1'b0;
		waitHi("done", rspValid, 20, n);
		r = rspRdata;
		@(negedge clk);
	endtask
	task automatic t_powerup();
		int n;
		waitHi("ready", reqReady, 40, n);
		chk("power-up wait", 15'h1, {14'h0, n >= PUP});
	endtask
	task automatic t_rw();
		logic [7:0] r;
		for (int i = 0; i < 3; i++) acc(1'b1, adr[i], dat[i], r);
		for (int i = 0; i < 3; i++) begin
			acc(1'b0, adr[i], 8'h00, r);
			chk("read data", {7'h0, dat[i]}, {7'h0, r});
		end
	endtask
	task automatic t_pwrdn();
		logic [7:0] r;
		int n;
		pwrDownReq = 1'b1;
		waitHi("safe", pwrDownSafe, 20, n);
		chk("idle pins", 15'h1, {14'h0, selN && !reqReady});
		pwrDownReq = 1'b0;
		@(negedge clk);
		acc(1'b0, adr[1], 8'h00, r);
		chk("read after", {7'h0, dat[1]}, {7'h0, r});
	endtask
	task automatic t_rerun();
		logic [7:0] r;
		rst_n = 1'b0;
		repeat (2) @(negedge clk);
		chk("reset pins", 15'h1, {14'h0, selN && !reqReady && !dataOe});
		rst_n = 1'b1;
		t_powerup();
		acc(1'b0, adr[2], 8'h00, r);
		chk("kept data", {7'h0, dat[2]}, {7'h0, r});
	endtask
	task automatic test_done();
		$display("checks %0d errors %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	initial begin
		repeat (10) @(negedge clk);
		rst_n = 1'b1;
		t_powerup();
		t_rw();
		t_pwrdn();
		t_rerun();
		test_done();
	end
	// hang guard
	always @(posedge clk) begin
		cycles++;
		if (cycles == 3000) begin
			num_errors++;
			$display("[FAIL] run exp end got timeout");
			test_done();
		end
	end
endmodule // fhc_host_tb
bind fhc_host fhc_checker #(.PWRUP_CYC(PWRUP_CYC), .ADDR_W(ADDR_W))
	chk_u (.clk, .rst_n, .reqValid, .reqReady, .rspValid, .pwrDownSafe,
	.selN, .wrStrobeN, .outStrobeN, .dataOe, .addr_lines);
